// file: uart_with_flow_control_test.sv
`default_nettype none
// ==========================================
// Self-checking bench
module uart_with_flow_control_test
    import uwf_pkg::*;
    ;
    timeunit 1ns;
    timeprecision 1ps;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic        txd, rxd, rts_n, cts_n, got, txr, rxv;
    logic [3:0]  act;
    logic [7:0]  paddr, b, rxdat;
    logic [9:0]  ev, evs;
    logic [31:0] pwdata, prdata;
    logic [11:0] frame;
    logic [32:0] aq[$];
    logic [11:0] fq[$];
    int          miscompares = 0, samples_checked = 0, cyc = 0;
    // Clock
    initial
    begin
        pclk = 1'b0;
        forever #4 pclk = ~pclk;
    end
    uwf_top dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .rxd(rxd), .txd(txd), .clear_to_send_n(cts_n),
        .request_to_send_n(rts_n), .dma_tx_valid(1'b0), .dma_tx_data(8'h00),
        .dma_tx_ready(txr), .dma_rx_valid(rxv), .dma_rx_data(rxdat), .dma_rx_take(1'b0),
        .dma_rx_buf_b(1'b0), .dma_rx_offset(16'h0000), .tx_buf_a_active(act[0]),
        .tx_buf_b_active(act[1]), .rx_buf_a_active(act[2]), .rx_buf_b_active(act[3]),
        .event_out(ev));
    uwf_peer peer (.txd(txd), .rxd(rxd), .frame(frame), .got(got));
    // Sticky record of event pulses
    always @(posedge pclk)
        evs <= presetn ? (evs | ev) : 10'h0;
    task automatic chk(input string n, input logic [32:0] e, input logic [32:0] g);
        samples_checked++;
        if (g !== e)
        begin
            miscompares++;
            $display("CHECK FAILED %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic close_out();
        if (miscompares == 0 && samples_checked > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    // Hang guard
    always @(posedge pclk)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            miscompares++;
            close_out();
        end
    end
    // Compare answers against the oldest note
    always @(posedge pclk)
        if (psel && penable && pready === 1'b1 && !pwrite)
            chk("apb read", aq.pop_front(), {pslverr, prdata});
    always @(posedge got)
        chk("tx frame", {21'h0, fq.pop_front()}, {21'h0, frame});
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1)
            @(posedge pclk);
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    task automatic rd(input logic [7:0] a, input logic [32:0] e);
        aq.push_back(e);
        apb(1'b0, a, 32'h0);
    endtask
    // Main sequence
    initial
    begin
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        cts_n = 1'b1;
        void'($urandom(42262));
        act = 4'($urandom);
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        rd(ADDR_CTRL, {26'h0, CTL_RST});
        rd(ADDR_BRI, {17'h0, BRI_RST});
        rd(8'h40, {1'b1, 32'h0});
        apb(1'b1, ADDR_BRI, 32'h8);
        apb(1'b1, ADDR_CTRL, 32'h7);
        apb(1'b1, ADDR_EVEN, 32'h3ff);
        b = 8'($urandom);
        fq.push_back({2'b11, ~^b, b, 1'b0});
        apb(1'b1, ADDR_DATA, {24'h0, b});
        wait (fq.size() == 0);
        for (int k = 0; k < 2; k++)
        begin
            b = 8'($urandom);
            peer.send({1'b1, ~^b ^ k[0], b, 1'b0});
            repeat (8) @(posedge pclk);
            chk("dma", {23'h0, 2'b11, b}, {23'h0, txr, rxv, rxdat});
            rd(ADDR_DATA, {24'h0, k[0], b});
        end
        // Handshake on, seven data bits, one stop, no parity
        apb(1'b1, ADDR_CTRL, 32'h48);
        b = 8'($urandom);
        fq.push_back({4'hf, b[6:0], 1'b0});
        apb(1'b1, ADDR_DATA, {24'h0, b});
        repeat (50) @(posedge pclk);
        chk("cts hold", 33'h1, {32'h0, txd});
        cts_n <= 1'b0;
        repeat (200) @(posedge pclk);
        cts_n <= 1'b1;
        wait (fq.size() == 0);
        @(posedge pclk);
        // Buffer status falls, then event record
        b = {4'h0, act};
        act <= 4'h0;
        repeat (4) @(posedge pclk);
        chk("events", {23'h0, 3'b001, b[3:0], 3'b101}, {23'h0, evs});
        apb(1'b1, ADDR_CTRL, 32'h20);
        @(posedge pclk);
        chk("rts sw", 33'h1, {32'h0, rts_n});
        apb(1'b1, ADDR_CTRL, 32'h38);
        @(posedge pclk);
        chk("rts", 33'h0, {32'h0, rts_n});
        close_out();
    end
endmodule
`default_nettype wire

// file: uwf_peer.sv
`default_nettype none
// ==========================================
// Far-side serial device
module uwf_peer
(
    input  wire logic   txd,
    output logic        rxd,
    output logic [11:0] frame,
    output logic        got
);
    timeunit 1ns;
    timeprecision 1ps;
    localparam real BIT = 666.667;
    // Line rests high
    initial
    begin
        rxd = 1'b1;
        got = 1'b0;
    end
    // Send bits first to last, then idle
    task automatic send(input logic [10:0] bits);
        for (int i = 0; i < 11; i++)
        begin
            rxd <= bits[i];
            #(BIT);
        end
        rxd <= 1'b1;
    endtask
    // Capture twelve bit centres after a start edge
    initial
    forever
    begin
        @(negedge txd);
        #(BIT / 2);
        for (int i = 0; i < 12; i++)
        begin
            frame[i] = txd;
            #(BIT);
        end
        got = 1'b1;
        #1 got = 1'b0;
    end
endmodule
`default_nettype wire

// file: uwf_pkg.sv
`default_nettype none
// ==========================================
// Shared constants for the serial block
package uwf_pkg;
    // Clock rates in MHz, reference tick made by accumulation
    localparam int         CLK_MHZ      = 125;
    localparam int         REF_MHZ      = 24;
    localparam logic [7:0] ACC_STEP     = 8'(REF_MHZ);
    localparam logic [7:0] ACC_WRAP     = 8'(CLK_MHZ);
    // FIFO geometry
    localparam int         FIFO_DEPTH   = 4;
    localparam logic [2:0] FIFO_FULL    = 3'(FIFO_DEPTH);
    localparam logic [2:0] RTS_MAX_USED = 3'(FIFO_DEPTH - 2);
    localparam logic [15:0] OVR_AHEAD   = 16'(FIFO_DEPTH);
    // Frame lengths in bit times
    localparam logic [3:0] DATA_LEN8    = 4'h8;
    localparam logic [3:0] DATA_LEN7    = 4'h7;
    localparam logic [3:0] FRAME_FIXED  = 4'h2;
    localparam logic [3:0] FRAME_MIN    = 4'h9;
    localparam logic [3:0] FRAME_MAX    = 4'hc;
    // Register byte offsets
    localparam logic [7:0] ADDR_DATA    = 8'h00;
    localparam logic [7:0] ADDR_CTRL    = 8'h04;
    localparam logic [7:0] ADDR_BRI     = 8'h08;
    localparam logic [7:0] ADDR_BRF     = 8'h0c;
    localparam logic [7:0] ADDR_STAT    = 8'h10;
    localparam logic [7:0] ADDR_DMAC    = 8'h14;
    localparam logic [7:0] ADDR_ERRA    = 8'h18;
    localparam logic [7:0] ADDR_ERRB    = 8'h1c;
    localparam logic [7:0] ADDR_EVEN    = 8'h20;
    localparam logic [7:0] ADDR_EVSEL   = 8'h24;
    // serial_line_control fields
    localparam int         CTL_STOP2    = 0;
    localparam int         CTL_PAR_EN   = 1;
    localparam int         CTL_PAR_ODD  = 2;
    localparam int         CTL_HS_EN    = 3;
    localparam int         CTL_AUTO_RTS = 4;
    localparam int         CTL_RTS      = 5;
    localparam int         CTL_DATA7    = 6;
    localparam int         CTL_W        = 7;
    localparam logic [6:0] CTL_RST      = 7'h20;
    localparam logic [15:0] BRI_RST     = 16'h0068;
    // Status fields
    localparam int         ST_TXIDLE    = 0;
    localparam int         ST_TXSPACE   = 1;
    localparam int         ST_RXVAL     = 2;
    localparam int         ST_OVR       = 3;
    localparam int         ST_TXCNT     = 4;
    localparam int         ST_RXCNT     = 8;
    localparam int         DMAC_RX_DMA_RESET   = 0;
    localparam int         ERR_VALID    = 16;
    // Events
    localparam int         EV_W         = 10;
    localparam int         EV_LVL_W     = 3;
    localparam int         EV_TXIDLE    = 0;
    typedef enum logic [1:0] {TX_IDLE = 2'b00, TX_SHIFT = 2'b01} uwf_tx_t;
    typedef enum logic [1:0] {RX_IDLE = 2'b00, RX_START = 2'b01, RX_BITS = 2'b10} uwf_rx_t;
endpackage
`default_nettype wire

// file: uwf_top.sv
`default_nettype none
// Operation
// (R1) Bit period is 2N+F ticks of a 24 MHz reference.
// (R2) Software keeps the integer divisor at 8 or more.
// (R3) Transmit one stop bit, or two when the stop bit is set.
// (R4) Receiver checks only one stop bit.
// (R5) Parity enable adds a parity bit both ways.
// (R6) Parity is XOR of data bits, inverted when odd selected.
// (R7) Frame: start, data LSB first, optional parity, stop bits.
// (R8) Frame spans 9 to 12 bit times.
// (R9) Lines idle high; a character starts with a falling edge.
// (R10) Four-deep FIFOs; data port writes push, reads pop.
// (R11) With handshake on, start only while clear-to-send is low.
// (R12) A started character always completes.
// (R13) Auto request: drive low when two or more FIFO slots free.
// (R14) Without auto request, pin follows the software bit.
// (R15) Handshake off: no gating on transmit.
// (R16) Receive DMA records offset of first errored character per buffer.
// (R17) Overrun flags at once, records offset four characters ahead.
// (R18) Error record cleared by DMA reset or buffer reload.
// (R19) Transmit idle event, edge or level.
// (R20) Transmit space event, edge or level.
// (R21) Receive valid event, edge or level.
// (R22) Buffer complete events on falling active status.
// (R23) Events for parity error, framing error and lost character.
// (R24) Character arriving into a full FIFO is lost, overrun set.
// (R25) Data length of seven or eight bits selectable.
// (R26) Start bit verified mid-bit; later bits sampled at centre.
module uwf_top
    import uwf_pkg::*;
(
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output var  logic [31:0] prdata,
    output var  logic        pready,
    output var  logic        pslverr,
    input  wire logic        rxd,
    output var  logic        txd,
    input  wire logic        clear_to_send_n,
    output var  logic        request_to_send_n,
    input  wire logic        dma_tx_valid,
    input  wire logic [7:0]  dma_tx_data,
    output var  logic        dma_tx_ready,
    output var  logic        dma_rx_valid,
    output var  logic [7:0]  dma_rx_data,
    input  wire logic        dma_rx_take,
    input  wire logic        dma_rx_buf_b,
    input  wire logic [15:0] dma_rx_offset,
    input  wire logic        tx_buf_a_active,
    input  wire logic        tx_buf_b_active,
    input  wire logic        rx_buf_a_active,
    input  wire logic        rx_buf_b_active,
    output var  logic [9:0]  event_out
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    // ==========================================
    // Registers and decode
    logic [CTL_W-1:0]    ctrl_r;
    logic [15:0]         bri_r;
    logic                brf_r;
    logic [EV_W-1:0]     even_r;
    logic [EV_LVL_W-1:0] evsel_r;
    logic                ovr_r;
    logic                apb_pend, wr_en, rd_en, rx_dma_reset;
    logic [31:0]         rd_val;
    logic                rd_ok;
    logic                hs_en, auto_rts, par_en, data7;
    logic [3:0]          dlen;

    assign apb_pend = psel && penable && !pready;
    assign wr_en    = psel && penable && pready && pwrite;
    assign rd_en    = psel && penable && pready && !pwrite;
    assign rx_dma_reset    = wr_en && paddr == ADDR_DMAC && pwdata[DMAC_RX_DMA_RESET];
    assign hs_en    = ctrl_r[CTL_HS_EN];
    assign auto_rts = ctrl_r[CTL_AUTO_RTS];
    assign par_en   = ctrl_r[CTL_PAR_EN];
    assign data7    = ctrl_r[CTL_DATA7];
    assign dlen     = data7 ? DATA_LEN7 : DATA_LEN8;                  // [R25]

    // ==========================================
    // FIFO storage
    logic [7:0] tx_mem [FIFO_DEPTH];
    logic [9:0] rx_mem [FIFO_DEPTH];
    logic [1:0] tx_wr_r, tx_rd_r, rx_wr_r, rx_rd_r;
    logic [2:0] tx_cnt_r, rx_cnt_r;
    logic       tx_push, tx_pop, rx_push, rx_pop, rx_full, rx_done;
    logic       tx_go, rx_pe, rx_fe, dma_pop;
    logic [7:0] rx_data;

    // Pushes from data port or DMA, pops by shifter
    assign tx_push = ((wr_en && paddr == ADDR_DATA) || (dma_tx_valid && dma_tx_ready))
                     && tx_cnt_r != FIFO_FULL;                         // [R10]
    assign tx_pop  = tx_go;
    assign rx_full = rx_cnt_r == FIFO_FULL;
    assign rx_push = rx_done && !rx_full;                              // [R24]
    assign dma_pop = dma_rx_valid && dma_rx_take;
    assign rx_pop  = ((rd_en && paddr == ADDR_DATA) || dma_pop) && rx_cnt_r != 3'h0;

    // Transmit FIFO
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            tx_wr_r  <= 2'h0;
            tx_rd_r  <= 2'h0;
            tx_cnt_r <= 3'h0;
        end
        else
        begin
            if (tx_push)
            begin
                tx_mem[tx_wr_r] <= (wr_en && paddr == ADDR_DATA) ? pwdata[7:0] : dma_tx_data;
                tx_wr_r         <= tx_wr_r + 2'h1;
            end
            if (tx_pop)
                tx_rd_r <= tx_rd_r + 2'h1;
            tx_cnt_r <= tx_cnt_r + 3'(tx_push) - 3'(tx_pop);
        end
    end

    // Receive FIFO, flags stored beside data
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            rx_wr_r  <= 2'h0;
            rx_rd_r  <= 2'h0;
            rx_cnt_r <= 3'h0;
        end
        else
        begin
            if (rx_push)
            begin
                rx_mem[rx_wr_r] <= {rx_fe, rx_pe, rx_data};           // [R10]
                rx_wr_r         <= rx_wr_r + 2'h1;
            end
            if (rx_pop)
                rx_rd_r <= rx_rd_r + 2'h1;
            rx_cnt_r <= rx_cnt_r + 3'(rx_push) - 3'(rx_pop);
        end
    end

    // DMA handshakes, masked while a data port access is due
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            dma_tx_ready <= 1'b0;
            dma_rx_valid <= 1'b0;
            dma_rx_data  <= 8'h00;
        end
        else
        begin
            dma_tx_ready <= tx_cnt_r + 3'(tx_push) - 3'(tx_pop) != FIFO_FULL
                            && !(apb_pend && pwrite && paddr == ADDR_DATA);
            dma_rx_valid <= rx_cnt_r != 3'h0 && !rx_pop
                            && !(apb_pend && !pwrite && paddr == ADDR_DATA);
            dma_rx_data  <= rx_mem[rx_rd_r][7:0];
        end
    end

    // ==========================================
    // Baud reference and bit period
    logic [7:0]  acc_r;
    logic        ref_tick_r;
    logic [16:0] bit_per;

    assign bit_per = {bri_r, 1'b0} + 17'(brf_r);                       // [R1]

    // 24 MHz tick from the 125 MHz clock
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            acc_r      <= 8'h00;
            ref_tick_r <= 1'b0;
        end
        else if (acc_r + ACC_STEP >= ACC_WRAP)
        begin
            acc_r      <= acc_r + ACC_STEP - ACC_WRAP;                 // [R1]
            ref_tick_r <= 1'b1;
        end
        else
        begin
            acc_r      <= acc_r + ACC_STEP;
            ref_tick_r <= 1'b0;
        end
    end

    // ==========================================
    // Transmitter
    uwf_tx_t     tx_st_r;
    logic [11:0] tx_sh_r, tx_word;
    logic [3:0]  tx_left_r, tx_len;
    logic [16:0] tx_tcnt_r;
    logic        tx_par, tx_busy;

    assign tx_busy = tx_st_r == TX_SHIFT;
    assign tx_go   = !tx_busy && tx_cnt_r != 3'h0
                     && (!hs_en || !clear_to_send_n);                  // [R11] [R15]

    // Frame image after the start bit, stop ones above
    always_comb
    begin
        tx_word = {4'hf, tx_mem[tx_rd_r]};
        if (data7)
            tx_word[7] = 1'b1;
        tx_par = ^(tx_word[7:0] & {!data7, 7'h7f}) ^ ctrl_r[CTL_PAR_ODD];  // [R6]
        if (par_en)
            tx_word[dlen] = tx_par;                                    // [R5]
        tx_len = dlen + 4'(par_en) + 4'(ctrl_r[CTL_STOP2]) + FRAME_FIXED;  // [R3] [R8]
    end

    // Shifter, start bit then LSB first
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            tx_st_r   <= TX_IDLE;
            txd       <= 1'b1;
            tx_sh_r   <= 12'hfff;
            tx_left_r <= 4'h0;
            tx_tcnt_r <= 17'h0;
        end
        else
        begin
            unique case (tx_st_r)
                TX_IDLE:
                begin
                    txd <= 1'b1;                                       // [R9]
                    if (tx_go)
                    begin
                        txd       <= 1'b0;                             // [R7]
                        tx_sh_r   <= tx_word;
                        tx_left_r <= tx_len - 4'h1;
                        tx_tcnt_r <= bit_per - 17'h1;
                        tx_st_r   <= TX_SHIFT;
                    end
                end
                TX_SHIFT:
                begin
                    if (ref_tick_r && tx_tcnt_r == 17'h0)
                    begin
                        if (tx_left_r == 4'h0)
                            tx_st_r <= TX_IDLE;                        // [R12]
                        else
                        begin
                            txd       <= tx_sh_r[0];
                            tx_sh_r   <= {1'b1, tx_sh_r[11:1]};
                            tx_left_r <= tx_left_r - 4'h1;
                            tx_tcnt_r <= bit_per - 17'h1;
                        end
                    end
                    else if (ref_tick_r)
                        tx_tcnt_r <= tx_tcnt_r - 17'h1;
                end
            endcase
        end
    end

    // ==========================================
    // Receiver
    uwf_rx_t     rx_st_r;
    logic [9:0]  rx_sh_r;
    logic [3:0]  rx_idx_r;
    logic [16:0] rx_tcnt_r;
    logic        rxd_q_r, rx_samp;

    assign rx_samp = ref_tick_r && rx_tcnt_r == 17'h0;
    assign rx_done = rx_st_r == RX_BITS && rx_samp && rx_idx_r == dlen + 4'(par_en);
    assign rx_data = data7 ? {1'b0, rx_sh_r[6:0]} : rx_sh_r[7:0];
    assign rx_pe   = par_en && (^rx_data ^ ctrl_r[CTL_PAR_ODD] ^ rx_sh_r[dlen]);  // [R6]
    assign rx_fe   = !rxd;                                             // [R4]

    // Mid-bit start check, centre sampling
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            rx_st_r   <= RX_IDLE;
            rxd_q_r   <= 1'b1;
            rx_sh_r   <= 10'h000;
            rx_idx_r  <= 4'h0;
            rx_tcnt_r <= 17'h0;
        end
        else
        begin
            rxd_q_r <= rxd;
            if (ref_tick_r && rx_tcnt_r != 17'h0)
                rx_tcnt_r <= rx_tcnt_r - 17'h1;
            unique case (rx_st_r)
                RX_IDLE:
                    if (rxd_q_r && !rxd)                               // [R9]
                    begin
                        rx_tcnt_r <= 17'(bri_r) - 17'h1;
                        rx_st_r   <= RX_START;
                    end
                RX_START:
                    if (rx_samp)
                    begin
                        rx_st_r   <= rxd ? RX_IDLE : RX_BITS;          // [R26]
                        rx_tcnt_r <= bit_per - 17'h1;
                        rx_idx_r  <= 4'h0;
                    end
                RX_BITS:
                    if (rx_samp)
                    begin
                        rx_sh_r[rx_idx_r] <= rxd;                      // [R5] [R7]
                        rx_idx_r          <= rx_idx_r + 4'h1;
                        rx_tcnt_r         <= bit_per - 17'h1;
                        if (rx_done)
                            rx_st_r <= RX_IDLE;                        // [R4]
                    end
                default:
                    rx_st_r <= RX_IDLE;
            endcase
        end
    end

    // ==========================================
    // Request-to-send pin
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            request_to_send_n <= 1'b1;
        else if (hs_en && auto_rts)
            request_to_send_n <= rx_cnt_r > RTS_MAX_USED;              // [R13]
        else
            request_to_send_n <= ctrl_r[CTL_RTS];                      // [R14]
    end

    // ==========================================
    // Receive DMA error offsets per buffer
    logic [1:0]  rxb_act, rxb_prev_r, err_v_r;
    logic [15:0] err_off_r [2];
    logic        dma_err;

    assign rxb_act = {rx_buf_b_active, rx_buf_a_active};
    assign dma_err = dma_pop && rx_mem[rx_rd_r][9:8] != 2'h0;

    for (genvar i = 0; i < 2; i++)
    begin : g_err
        always_ff @(posedge pclk or negedge presetn)
        begin
            if (!presetn)
            begin
                err_v_r[i]   <= 1'b0;
                err_off_r[i] <= 16'h0000;
            end
            else if (dma_rx_buf_b == (i == 1) && !err_v_r[i] && dma_err)
            begin
                err_v_r[i]   <= 1'b1;                                  // [R16]
                err_off_r[i] <= dma_rx_offset;
            end
            else if (dma_rx_buf_b == (i == 1) && !err_v_r[i] && rx_done && rx_full)
            begin
                err_v_r[i]   <= 1'b1;                                  // [R17]
                err_off_r[i] <= dma_rx_offset + OVR_AHEAD;
            end
            else if (rx_dma_reset || (rxb_act[i] && !rxb_prev_r[i]))
                err_v_r[i] <= 1'b0;                                    // [R18]
        end
    end

    // ==========================================
    // Events
    logic [EV_LVL_W-1:0] lvl, lvl_prev_r, lvl_ev;
    logic [3:0]          act, act_prev_r;

    assign lvl    = {rx_cnt_r != 3'h0, tx_cnt_r != FIFO_FULL,
                     !tx_busy && tx_cnt_r == 3'h0};
    assign act    = {rxb_act, tx_buf_b_active, tx_buf_a_active};
    assign lvl_ev = (evsel_r & lvl) | (~evsel_r & lvl & ~lvl_prev_r);  // [R19] [R20] [R21]

    // Edge history and gated event outputs
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            lvl_prev_r <= '0;
            act_prev_r <= 4'h0;
            rxb_prev_r <= 2'h0;
            event_out  <= '0;
        end
        else
        begin
            lvl_prev_r <= lvl;
            act_prev_r <= act;
            rxb_prev_r <= rxb_act;
            event_out  <= even_r & {rx_done && rx_full, rx_done && rx_fe,
                                    rx_done && rx_pe, act_prev_r & ~act, lvl_ev};  // [R22] [R23]
        end
    end

    // ==========================================
    // APB register file
    always_comb
    begin
        rd_val = 32'h0;
        rd_ok  = 1'b1;
        case (paddr)
            ADDR_DATA:  rd_val = (rx_cnt_r != 3'h0) ? 32'(rx_mem[rx_rd_r]) : 32'h0;
            ADDR_CTRL:  rd_val = 32'(ctrl_r);
            ADDR_BRI:   rd_val = 32'(bri_r);
            ADDR_BRF:   rd_val = 32'(brf_r);
            ADDR_STAT:
            begin
                rd_val[ST_TXIDLE]           = lvl[0];
                rd_val[ST_TXSPACE]          = lvl[1];
                rd_val[ST_RXVAL]            = lvl[2];
                rd_val[ST_OVR]              = ovr_r;
                rd_val[ST_TXCNT +: 3]       = tx_cnt_r;
                rd_val[ST_RXCNT +: 3]       = rx_cnt_r;
            end
            ADDR_DMAC:  rd_val = 32'h0;
            ADDR_ERRA:  rd_val = 32'({err_v_r[0], err_off_r[0]});
            ADDR_ERRB:  rd_val = 32'({err_v_r[1], err_off_r[1]});
            ADDR_EVEN:  rd_val = 32'(even_r);
            ADDR_EVSEL: rd_val = 32'(evsel_r);
            default:    rd_ok  = 1'b0;
        endcase
    end

    // One wait state, answer registered
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pready  <= 1'b0;
            prdata  <= 32'h0;
            pslverr <= 1'b0;
        end
        else
        begin
            pready  <= apb_pend;
            prdata  <= apb_pend && !pwrite ? rd_val : 32'h0;
            pslverr <= apb_pend && !rd_ok;
        end
    end

    // Writable configuration
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            ctrl_r  <= CTL_RST;
            bri_r   <= BRI_RST;
            brf_r   <= 1'b0;
            even_r  <= '0;
            evsel_r <= '0;
        end
        else if (wr_en)
        begin
            case (paddr)
                ADDR_CTRL:  ctrl_r  <= pwdata[CTL_W-1:0];
                ADDR_BRI:   bri_r   <= pwdata[15:0];
                ADDR_BRF:   brf_r   <= pwdata[0];
                ADDR_EVEN:  even_r  <= pwdata[EV_W-1:0];
                ADDR_EVSEL: evsel_r <= pwdata[EV_LVL_W-1:0];
                default:    ;
            endcase
        end
    end

    // Overrun flag, set wins over write-one clear
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            ovr_r <= 1'b0;
        else if (rx_done && rx_full)
            ovr_r <= 1'b1;                                             // [R17] [R24]
        else if (wr_en && paddr == ADDR_STAT && pwdata[ST_OVR])
            ovr_r <= 1'b0;
    end

    // ==========================================
    // Assertions
    property p_cts_gate;
        $rose(tx_busy) |-> !$past(hs_en) || !$past(clear_to_send_n);
    endproperty
    a_cts_gate: assert property (p_cts_gate) else $error("start without cts"); // [R11]

    property p_finish;
        tx_busy && tx_left_r != 4'h0 |=> tx_busy;
    endproperty
    a_finish: assert property (p_finish) else $error("frame cut short"); // [R12]

    property p_start_low;
        $rose(tx_busy) |-> !txd ##1 !txd;
    endproperty
    a_start_low: assert property (p_start_low) else $error("no start bit"); // [R7]

    property p_idle_high;
        !tx_busy && $past(!tx_busy) |-> txd;
    endproperty
    a_idle_high: assert property (p_idle_high) else $error("idle line low"); // [R9]

    property p_frame_len;
        tx_go |=> tx_left_r >= FRAME_MIN - 4'h1 && tx_left_r <= FRAME_MAX - 4'h1;
    endproperty
    a_frame_len: assert property (p_frame_len) else $error("bad frame length"); // [R8]

    property p_baud;
        $rose(tx_busy) |-> tx_tcnt_r == {$past(bri_r), 1'b0} + 17'($past(brf_r)) - 17'h1;
    endproperty
    a_baud: assert property (p_baud) else $error("bad bit period"); // [R1]

    property p_rts_auto;
        hs_en && auto_rts && rx_cnt_r <= RTS_MAX_USED |=> !request_to_send_n;
    endproperty
    a_rts_auto: assert property (p_rts_auto) else $error("rts not asserted"); // [R13]

    property p_rts_sw;
        !(hs_en && auto_rts) |=> request_to_send_n == $past(ctrl_r[CTL_RTS]);
    endproperty
    a_rts_sw: assert property (p_rts_sw) else $error("rts not software"); // [R14]

    property p_ovr;
        rx_done && rx_full |=> ovr_r && rx_wr_r == $past(rx_wr_r);
    endproperty
    a_ovr: assert property (p_ovr) else $error("overrun missed"); // [R24]

    property p_false_start;
        rx_st_r == RX_START && rx_samp && rxd |=> rx_st_r == RX_IDLE;
    endproperty
    a_false_start: assert property (p_false_start) else $error("false start taken"); // [R26]
endmodule
`default_nettype wire
